// ### rtl/rtp_consts.svh
// Constants for the set-tag-protection command handler.
`ifndef RTP_CONSTS_SVH
`define RTP_CONSTS_SVH

`define RTP_ADDR_CMD          8'h00
`define RTP_ADDR_REQ          8'h04
`define RTP_ADDR_WD0          8'h08
`define RTP_ADDR_WD1          8'h0C
`define RTP_ADDR_WD2          8'h10
`define RTP_ADDR_WD3          8'h14
`define RTP_ADDR_CFG          8'h18
`define RTP_ADDR_RESP         8'h1C
`define RTP_ADDR_STAT         8'h20

`define RTP_CMD_LSB           0
`define RTP_LOOP_LSB          16
`define RTP_UIDLEN_LSB        0
`define RTP_AREA_LSB          8
`define RTP_LEN_LSB           16
`define RTP_CFG_SEVERAL_BIT   0
`define RTP_CFG_UHF_BIT       1
`define RTP_CFG_HF20_BIT      2
`define RTP_CFG_RESET         3'h0

`define RTP_CMD_SET_PROT      16'h0103
`define RTP_CMD_SET_PROT_FAST 16'h2103
`define RTP_CMD_PRECEDING     16'h0102

`define RTP_ERR_NONE          16'h0000
`define RTP_ERR_BITMAP        16'h2502
`define RTP_ERR_UNKNOWN       16'h2601
`define RTP_ERR_MULTITAG      16'h2602
`define RTP_ERR_NO_TAG        16'h2603
`define RTP_ERR_UID_LEN       16'h2604
`define RTP_ERR_MISMATCH      16'h2605
`define RTP_ERR_AREA          16'h2606
`define RTP_ERR_LENGTH        16'h2607

`define RTP_AREA_PC_EPC       8'h01
`define RTP_AREA_USER         8'h03
`define RTP_LEN_UHF           8'h00
`define RTP_LEN_HF            8'h08
`define RTP_UID_NEXT          8'hFF
`define RTP_UID_MAX           8'h10
`define RTP_UID_BYTES         16
`define RTP_PAGES             20
`define RTP_LAST_PAGE         19
`define RTP_BLOCKS            80
`define RTP_HF_SMALL_MASK     20'h000FF
`define RTP_WR_FRAGMENT       8'h00

`endif

// ### rtl/rtp_pkg.sv
// Types shared by the set-tag-protection command handler.
package rtp_pkg;

  typedef enum logic [1:0] {
    rtp_st_idle,
    rtp_st_eval,
    rtp_st_run
  } rtp_state_type;

  typedef struct packed {
    rtp_state_type st;
    logic          busy;
    logic [15:0]   cmd;
    logic [7:0]    loop;
    logic [7:0]    uid_len;
    logic [7:0]    area;
    logic [7:0]    len;
    logic [127:0]  wdata;
    logic          several;
    logic          uhf;
    logic          hf20;
    logic [15:0]   resp;
    logic [15:0]   err;
    logic [7:0]    resp_loop;
    logic          done;
    logic [127:0]  last_id;
    logic          last_valid;
    logic [1:0]    uhf_lock;
    logic [31:0]   rdata;
    logic          start;
    logic          out_uhf;
    logic [7:0]    out_area;
    logic [79:0]   wrb;
    logic [79:0]   rdb;
  } rtp_top_state_type;

endpackage

// ### rtl/rtp_sub_if.sv
// Signals between the command handler and its bitmap and tag-selection helpers.
`timescale 1ns/1ns
`default_nettype none

interface rtp_sub_if;
  logic [19:0]  wr_map;
  logic [19:0]  rd_map;
  logic         hf20;
  logic         map_ok;
  logic         resv_ok;
  logic [79:0]  wr_blocks;
  logic [79:0]  rd_blocks;
  logic [7:0]   uid_len;
  logic [127:0] wdata;
  logic [127:0] tag_id;
  logic [127:0] last_id;
  logic         last_valid;
  logic         tag_hit;
  logic         len_bad;

  modport top_mp (output wr_map, rd_map, hf20, uid_len, wdata, tag_id, last_id, last_valid,
                  input map_ok, resv_ok, wr_blocks, rd_blocks, tag_hit, len_bad);
  modport check_mp (input wr_map, rd_map, hf20, wdata,
                    output map_ok, resv_ok, wr_blocks, rd_blocks);
  modport match_mp (input uid_len, wdata, tag_id, last_id, last_valid,
                    output tag_hit, len_bad);
endinterface

`default_nettype wire

// ### rtl/rtp_bitmap_check.sv
// Page bitmap checks and page-to-block expansion for HF protection requests.
`timescale 1ns/1ns
`default_nettype none
`include "rtp_consts.svh"

module rtp_bitmap_check (
  rtp_sub_if.check_mp chk
);
  logic [19:0] wr_eff;
  logic [18:0] gap_w;
  logic [18:0] gap_r;
  logic        same_ok;

  // Read protection implies write protection.
  assign wr_eff = chk.wr_map | chk.rd_map;
  assign same_ok = (chk.wr_map == chk.rd_map) || (chk.rd_map == 20'h00000) ||
                   (chk.wr_map == 20'h00000);

  genvar i;
  generate
    for (i = 0; i < `RTP_LAST_PAGE; i++) begin : g_gap
      // A set page must be followed by a set page, so every run ends at the last page.
      assign gap_w[i] = chk.wr_map[i] & ~chk.wr_map[i+1];
      assign gap_r[i] = chk.rd_map[i] & ~chk.rd_map[i+1];
    end
  endgenerate

  assign chk.map_ok = !chk.hf20 || (same_ok && gap_w == 19'h00000 && gap_r == 19'h00000);
  assign chk.resv_ok = (chk.wdata[31:20] == 12'h000) && (chk.wdata[63:52] == 12'h000);

  genvar p;
  generate
    for (p = 0; p < `RTP_PAGES; p++) begin : g_page
      if (p == `RTP_LAST_PAGE) begin : g_last
        // The final page has three blocks; the top block stays open.
        assign chk.wr_blocks[4*p +: 4] = {1'b0, {3{wr_eff[p]}}};
        assign chk.rd_blocks[4*p +: 4] = {1'b0, {3{chk.rd_map[p]}}};
      end else begin : g_full
        assign chk.wr_blocks[4*p +: 4] = {4{wr_eff[p]}};
        assign chk.rd_blocks[4*p +: 4] = {4{chk.rd_map[p]}};
      end
    end
  endgenerate
endmodule

`default_nettype wire

// ### rtl/rtp_tag_match.sv
// Selects whether the tag in range is the one the request names.
`timescale 1ns/1ns
`default_nettype none
`include "rtp_consts.svh"

module rtp_tag_match (
  rtp_sub_if.match_mp m
);
  logic [15:0] byte_eq;

  genvar i;
  generate
    for (i = 0; i < `RTP_UID_BYTES; i++) begin : g_byte
      assign byte_eq[i] = (8'(i) >= m.uid_len) ||
                          (m.wdata[8*i +: 8] == m.tag_id[8*i +: 8]);
    end
  endgenerate

  always_comb begin
    m.len_bad = 1'b0;
    m.tag_hit = 1'b0;
    if (m.uid_len == 8'h00) begin
      m.tag_hit = 1'b1;
    end else if (m.uid_len == `RTP_UID_NEXT) begin
      m.tag_hit = !(m.last_valid && m.tag_id == m.last_id);
    end else if (m.uid_len[7] || m.uid_len > `RTP_UID_MAX) begin
      m.len_bad = 1'b1;
    end else begin
      m.tag_hit = &byte_eq;
    end
  end
endmodule

`default_nettype wire

// ### rtl/rfid_tag_protection_command.sv
// Set-tag-protection command handler with its register port and protection engine port.
`timescale 1ns/1ns
`default_nettype none
`include "rtp_consts.svh"

// Overview of operation
// - Command code 0x0103 in the command field starts the set-protection request.
// - Alternate code 0x2103 starts the same request for loop-counter fast processing.
// - One UHF request carries protection for its one selected area to the engine.
// - HF request with the several-tag option on is refused with a fault.
// - Any read-protected page is also write protected.
// - Twenty-page HF maps: equal, or all read bits zero, or all write zero.
// - Twenty-page HF set bits form one gap-free run ending at page 19.
// - A bitmap violation is refused with error code 0x2502.
// - Pages span four blocks; page 19 spans three and block 79 stays open.
// - UHF write protection, once applied, cannot be undone by this block.
// - Identifier length zero acts on the single tag currently in range.
// - Length 1 to 16 compares that many write-data bytes against the tag identifier.
// - Length -1 acts only if the tag differs from the last one handled.
// - Area codes 1 and 3 are valid; UHF 1 is PC/EPC, 3 user.
// - A UHF request protects the whole selected area as one unit.
// - Write-data byte 0 bit n write-protects HF page n, pages 0 to 7.
// - The preceding command answers code 0x0102, write fragment 0, no read data.
// - Write-data byte 1 bits 0 to 7 write-protect twenty-page HF pages 8 to 15.
// - Write-data byte 4 bits 0 to 7 read-protect HF pages 0 to 7.

module rfid_tag_protection_command (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic         clk_en,
  input  wire logic [7:0]   reg_addr,
  input  wire logic [31:0]  reg_wdata,
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  output logic      [31:0]  reg_rdata,
  input  wire logic [7:0]   tags_in_range,
  input  wire logic [127:0] tag_id,
  input  wire logic         prot_done,
  input  wire logic         prot_fail,
  input  wire logic [15:0]  prot_err,
  output logic              prot_start,
  output logic              prot_uhf,
  output logic      [7:0]   prot_area,
  output logic      [79:0]  prot_wr_blocks,
  output logic      [79:0]  prot_rd_blocks,
  output logic              busy,
  output logic              done
);
  rtp_pkg::rtp_top_state_type s;
  rtp_pkg::rtp_top_state_type next_s;

  logic set_cmd;
  logic len_ok;
  logic area_ok;
  logic tag_ok;

  rtp_sub_if sub ();

  // HF page bitmaps: bytes 0..2 write, bytes 4..6 read, low bit is the lowest page.
  assign sub.wr_map     = s.hf20 ? s.wdata[19:0] : (s.wdata[19:0] & `RTP_HF_SMALL_MASK);
  assign sub.rd_map     = s.hf20 ? s.wdata[51:32] : (s.wdata[51:32] & `RTP_HF_SMALL_MASK);
  assign sub.hf20       = s.hf20;
  assign sub.uid_len    = s.uid_len;
  assign sub.wdata      = s.wdata;
  assign sub.tag_id     = tag_id;
  assign sub.last_id    = s.last_id;
  assign sub.last_valid = s.last_valid;

  rtp_bitmap_check u_check (
    .chk (sub.check_mp)
  );

  rtp_tag_match u_match (
    .m (sub.match_mp)
  );

  assign set_cmd = (s.cmd == `RTP_CMD_SET_PROT) || (s.cmd == `RTP_CMD_SET_PROT_FAST);
  assign len_ok  = s.uhf ? (s.len == `RTP_LEN_UHF) : (s.len == `RTP_LEN_HF);
  assign area_ok = !s.uhf || (s.area == `RTP_AREA_PC_EPC) || (s.area == `RTP_AREA_USER);
  // With no identifier given, only one tag may be in range.
  assign tag_ok  = (tags_in_range != 8'h00) &&
                   ((s.uid_len != 8'h00) || (tags_in_range == 8'h01));

  always_comb begin
    next_s = s;
    next_s.start = 1'b0;
    next_s.rdata = 32'h00000000;

    if (reg_wr) begin
      if (reg_addr == `RTP_ADDR_CMD) begin
        if (s.st == rtp_pkg::rtp_st_idle) begin
          next_s.cmd  = reg_wdata[`RTP_CMD_LSB +: 16];
          next_s.loop = reg_wdata[`RTP_LOOP_LSB +: 8];
          next_s.done = 1'b0;
          next_s.st   = rtp_pkg::rtp_st_eval;
        end
      end else if (reg_addr == `RTP_ADDR_REQ) begin
        if (s.st == rtp_pkg::rtp_st_idle) begin
          next_s.uid_len = reg_wdata[`RTP_UIDLEN_LSB +: 8];
          next_s.area    = reg_wdata[`RTP_AREA_LSB +: 8];
          next_s.len     = reg_wdata[`RTP_LEN_LSB +: 8];
        end
      end else if (reg_addr == `RTP_ADDR_WD0) begin
        if (s.st == rtp_pkg::rtp_st_idle) begin
          next_s.wdata[31:0] = reg_wdata;
        end
      end else if (reg_addr == `RTP_ADDR_WD1) begin
        if (s.st == rtp_pkg::rtp_st_idle) begin
          next_s.wdata[63:32] = reg_wdata;
        end
      end else if (reg_addr == `RTP_ADDR_WD2) begin
        if (s.st == rtp_pkg::rtp_st_idle) begin
          next_s.wdata[95:64] = reg_wdata;
        end
      end else if (reg_addr == `RTP_ADDR_WD3) begin
        if (s.st == rtp_pkg::rtp_st_idle) begin
          next_s.wdata[127:96] = reg_wdata;
        end
      end else if (reg_addr == `RTP_ADDR_CFG) begin
        if (s.st == rtp_pkg::rtp_st_idle) begin
          next_s.several = reg_wdata[`RTP_CFG_SEVERAL_BIT];
          next_s.uhf     = reg_wdata[`RTP_CFG_UHF_BIT];
          next_s.hf20    = reg_wdata[`RTP_CFG_HF20_BIT];
        end
      end
    end

    if (reg_rd) begin
      if (reg_addr == `RTP_ADDR_CMD) begin
        next_s.rdata = {8'h00, s.loop, s.cmd};
      end else if (reg_addr == `RTP_ADDR_REQ) begin
        next_s.rdata = {8'h00, s.len, s.area, s.uid_len};
      end else if (reg_addr == `RTP_ADDR_WD0) begin
        next_s.rdata = s.wdata[31:0];
      end else if (reg_addr == `RTP_ADDR_WD1) begin
        next_s.rdata = s.wdata[63:32];
      end else if (reg_addr == `RTP_ADDR_WD2) begin
        next_s.rdata = s.wdata[95:64];
      end else if (reg_addr == `RTP_ADDR_WD3) begin
        next_s.rdata = s.wdata[127:96];
      end else if (reg_addr == `RTP_ADDR_CFG) begin
        next_s.rdata = {29'h00000000, s.hf20, s.uhf, s.several};
      end else if (reg_addr == `RTP_ADDR_RESP) begin
        next_s.rdata = {s.err, s.resp};
      end else if (reg_addr == `RTP_ADDR_STAT) begin
        // Write fragment number is always zero and no read data is returned.
        next_s.rdata = {8'h00, s.resp_loop, `RTP_WR_FRAGMENT, 4'h0, s.uhf_lock, s.done,
                        (s.st != rtp_pkg::rtp_st_idle)};
      end else begin
        next_s.rdata = 32'h00000000;
      end
    end

    case (s.st)
      rtp_pkg::rtp_st_idle: begin
        next_s.start = 1'b0;
      end
      rtp_pkg::rtp_st_eval: begin
        next_s.st        = rtp_pkg::rtp_st_idle;
        next_s.done      = 1'b1;
        next_s.resp      = s.cmd;
        next_s.resp_loop = s.loop;
        if (s.cmd == `RTP_CMD_PRECEDING) begin
          next_s.err = `RTP_ERR_NONE;
        end else if (!set_cmd) begin
          next_s.err = `RTP_ERR_UNKNOWN;
        end else if (!s.uhf && s.several) begin
          next_s.err = `RTP_ERR_MULTITAG;
        end else if (!area_ok) begin
          next_s.err = `RTP_ERR_AREA;
        end else if (!len_ok) begin
          next_s.err = `RTP_ERR_LENGTH;
        end else if (!tag_ok) begin
          next_s.err = `RTP_ERR_NO_TAG;
        end else if (sub.len_bad) begin
          next_s.err = `RTP_ERR_UID_LEN;
        end else if (!s.uhf && !(sub.map_ok && sub.resv_ok)) begin
          next_s.err = `RTP_ERR_BITMAP;
        end else if (!sub.tag_hit) begin
          next_s.err = `RTP_ERR_MISMATCH;
        end else begin
          // The response stays as it was until the engine reports back.
          next_s.st        = rtp_pkg::rtp_st_run;
          next_s.done      = 1'b0;
          next_s.resp      = s.resp;
          next_s.resp_loop = s.resp_loop;
          next_s.start     = 1'b1;
          next_s.out_uhf   = s.uhf;
          if (s.uhf) begin
            // The whole area goes to the engine; block masks do not apply.
            next_s.out_area = s.area;
            next_s.wrb      = 80'h0;
            next_s.rdb      = 80'h0;
          end else begin
            next_s.out_area = 8'h00;
            next_s.wrb      = sub.wr_blocks;
            next_s.rdb      = sub.rd_blocks;
          end
        end
      end
      rtp_pkg::rtp_st_run: begin
        if (prot_done) begin
          next_s.st        = rtp_pkg::rtp_st_idle;
          next_s.done      = 1'b1;
          next_s.resp      = s.cmd;
          next_s.resp_loop = s.loop;
          next_s.err       = prot_fail ? prot_err : `RTP_ERR_NONE;
          if (!prot_fail) begin
            next_s.last_id    = tag_id;
            next_s.last_valid = 1'b1;
            if (s.out_uhf) begin
              // Lock flags only ever set; nothing here clears them.
              next_s.uhf_lock[s.out_area == `RTP_AREA_USER] = 1'b1;
            end
          end
        end
      end
      default: begin
        next_s.st = rtp_pkg::rtp_st_idle;
      end
    endcase
    // Busy is registered so that the output comes straight from a flip-flop.
    next_s.busy = (next_s.st != rtp_pkg::rtp_st_idle);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s.st         <= rtp_pkg::rtp_st_idle;
      s.busy       <= 1'b0;
      s.cmd        <= 16'h0000;
      s.loop       <= 8'h00;
      s.uid_len    <= 8'h00;
      s.area       <= 8'h00;
      s.len        <= 8'h00;
      s.wdata      <= 128'h0;
      s.several    <= 1'(`RTP_CFG_RESET >> `RTP_CFG_SEVERAL_BIT);
      s.uhf        <= 1'b0;
      s.hf20       <= 1'b0;
      s.resp       <= 16'h0000;
      s.err        <= `RTP_ERR_NONE;
      s.resp_loop  <= 8'h00;
      s.done       <= 1'b0;
      s.last_id    <= 128'h0;
      s.last_valid <= 1'b0;
      s.uhf_lock   <= 2'h0;
      s.rdata      <= 32'h00000000;
      s.start      <= 1'b0;
      s.out_uhf    <= 1'b0;
      s.out_area   <= 8'h00;
      s.wrb        <= 80'h0;
      s.rdb        <= 80'h0;
    end else if (clk_en) begin
      s <= next_s;
    end
  end

  assign reg_rdata      = s.rdata;
  assign prot_start     = s.start;
  assign prot_uhf       = s.out_uhf;
  assign prot_area      = s.out_area;
  assign prot_wr_blocks = s.wrb;
  assign prot_rd_blocks = s.rdb;
  assign busy           = s.busy;
  assign done           = s.done;
endmodule

`default_nettype wire

// ### verification/rtp_engine_model.sv
// Behavioural model of the protection engine behind the command handler.
`timescale 1ns/1ns
`default_nettype none

module rtp_engine_model (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        prot_start,
  input  wire logic [7:0]  delay,
  input  wire logic        fail_req,
  input  wire logic [15:0] err_val,
  output logic             prot_done,
  output logic             prot_fail,
  output logic      [15:0] prot_err,
  output logic      [15:0] start_cnt
);
  logic [7:0] cnt;

  // Outside the done pulse the status lines toggle so that stale values are never trusted.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt       <= 8'h00;
      prot_done <= 1'b0;
      prot_fail <= 1'b0;
      prot_err  <= 16'h0000;
      start_cnt <= 16'h0000;
    end else begin
      prot_done <= 1'b0;
      prot_fail <= ~prot_fail;
      prot_err  <= ~prot_err;
      if (prot_start) begin
        cnt       <= (delay == 8'h00) ? 8'h01 : delay;
        start_cnt <= start_cnt + 16'h0001;
      end else if (cnt == 8'h01) begin
        cnt       <= 8'h00;
        prot_done <= 1'b1;
        prot_fail <= fail_req;
        prot_err  <= err_val;
      end else if (cnt > 8'h01) begin
        cnt <= cnt - 8'h01;
      end
    end
  end
endmodule

`default_nettype wire

// ### verification/rtp_checker_properties.sv
// Concurrent checks on the ports of the set-tag-protection command handler.
`timescale 1ns/1ns
`default_nettype none
`include "rtp_consts.svh"

module rtp_checker (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        prot_done,
  input wire logic        prot_start,
  input wire logic        prot_uhf,
  input wire logic [7:0]  prot_area,
  input wire logic [79:0] prot_wr_blocks,
  input wire logic [79:0] prot_rd_blocks,
  input wire logic        busy,
  input wire logic        done
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  logic run_q;
  logic grp_ok;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      run_q <= 1'b0;
    end else begin
      run_q <= prot_start | (run_q & ~prot_done);
    end
  end

  // Every block of a page except block 79 must match the first block of that page.
  always_comb begin
    grp_ok = 1'b1;
    for (int b = 0; b < 79; b++) begin
      grp_ok = grp_ok & (prot_wr_blocks[b] == prot_wr_blocks[b - b % 4]);
      grp_ok = grp_ok & (prot_rd_blocks[b] == prot_rd_blocks[b - b % 4]);
    end
  end

  sequence s_cmd_taken;
    reg_wr && reg_addr == `RTP_ADDR_CMD && !busy;
  endsequence
  sequence s_settled;
    done && !busy;
  endsequence
  sequence s_decided;
    prot_start || (done && !busy);
  endsequence

  property p_eval;
    s_cmd_taken |=> busy && !done ##1 s_decided;
  endproperty
  property p_finish;
    run_q && prot_done |=> s_settled;
  endproperty
  property p_start_pulse;
    prot_start |=> !prot_start;
  endproperty
  property p_start_busy;
    prot_start |-> busy && !done;
  endproperty
  property p_area;
    prot_start |-> (prot_uhf ? (prot_area == `RTP_AREA_PC_EPC || prot_area == `RTP_AREA_USER)
                             : prot_area == 8'h00);
  endproperty
  property p_block79;
    !prot_wr_blocks[79] && !prot_rd_blocks[79];
  endproperty
  property p_rd_in_wr;
    (prot_rd_blocks & ~prot_wr_blocks) == 80'h0;
  endproperty
  property p_pages;
    !prot_uhf |-> grp_ok;
  endproperty
  property p_masks_hold;
    $changed(prot_wr_blocks) || $changed(prot_rd_blocks) |-> prot_start;
  endproperty
  property p_rdata;
    reg_rdata != 32'h0 |-> $past(reg_rd);
  endproperty

  a_eval:        assert property (p_eval) else $error("no decision after command");
  a_finish:      assert property (p_finish) else $error("no completion after done");
  a_start_pulse: assert property (p_start_pulse) else $error("start longer than one cycle");
  a_start_busy:  assert property (p_start_busy) else $error("start while idle");
  a_area:        assert property (p_area) else $error("bad area on start");
  a_block79:     assert property (p_block79) else $error("block 79 protected");
  a_rd_in_wr:    assert property (p_rd_in_wr) else $error("read block not write protected");
  a_pages:       assert property (p_pages) else $error("page blocks differ");
  a_masks_hold:  assert property (p_masks_hold) else $error("masks moved without start");
  a_rdata:       assert property (p_rdata) else $error("read data without read");
endmodule

bind rfid_tag_protection_command rtp_checker i_rtp_checker (
  .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .prot_done(prot_done), .prot_start(prot_start),
  .prot_uhf(prot_uhf), .prot_area(prot_area), .prot_wr_blocks(prot_wr_blocks),
  .prot_rd_blocks(prot_rd_blocks), .busy(busy), .done(done)
);

`default_nettype wire

// ### verification/rfid_tag_protection_command_tb_top.sv
// Testbench for the set-tag-protection command handler.
`timescale 1ns/1ns
`default_nettype none
`include "rtp_consts.svh"

module rfid_tag_protection_command_tb_top;
  logic         clk;
  logic         resetn;
  logic         clk_en;
  logic [7:0]   reg_addr;
  logic [31:0]  reg_wdata;
  logic         reg_wr;
  logic         reg_rd;
  logic [31:0]  reg_rdata;
  logic [7:0]   tags_in_range;
  logic [127:0] tag_id;
  logic         prot_done;
  logic         prot_fail;
  logic [15:0]  prot_err;
  logic         prot_start;
  logic         prot_uhf;
  logic [7:0]   prot_area;
  logic [79:0]  prot_wr_blocks;
  logic [79:0]  prot_rd_blocks;
  logic         busy;
  logic         done;
  logic [7:0]   eng_delay;
  logic         eng_fail;
  logic [15:0]  eng_err;
  logic [15:0]  start_cnt;
  logic [55:0]  hf_tab [6];
  logic [87:0]  uhf_tab [8];
  int           err_count;
  int           total_checks;

  rfid_tag_protection_command i_rfid_tag_protection_command (
    .clk(clk), .resetn(resetn), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tags_in_range(tags_in_range),
    .tag_id(tag_id), .prot_done(prot_done), .prot_fail(prot_fail), .prot_err(prot_err),
    .prot_start(prot_start), .prot_uhf(prot_uhf), .prot_area(prot_area),
    .prot_wr_blocks(prot_wr_blocks), .prot_rd_blocks(prot_rd_blocks), .busy(busy), .done(done)
  );

  rtp_engine_model i_rtp_engine_model (
    .clk(clk), .resetn(resetn), .prot_start(prot_start), .delay(eng_delay),
    .fail_req(eng_fail), .err_val(eng_err), .prot_done(prot_done), .prot_fail(prot_fail),
    .prot_err(prot_err), .start_cnt(start_cnt)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [79:0] blk(input logic [19:0] pages);
    logic [79:0] b;
    b = 80'h0;
    for (int p = 0; p < 20; p++) begin
      b[4*p +: 4] = {4{pages[p]}};
    end
    b[79] = 1'b0;
    return b;
  endfunction

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [79:0] exp, input logic [79:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check(what, {48'h0, exp}, {48'h0, reg_rdata});
  endtask

  task automatic run(input logic [31:0] cmd, input logic [31:0] resp, input logic started,
                     input logic poke);
    logic [15:0] n0;
    int          i;
    n0 = start_cnt;
    wr(`RTP_ADDR_CMD, cmd);
    if (poke) begin
      wr(`RTP_ADDR_CFG, 32'h0);
    end
    i = 0;
    #1;
    while (done !== 1'b1 && i < 200) begin
      @(posedge clk);
      #1;
      i++;
    end
    check("done", 80'h1, {79'h0, done});
    check("started", {79'h0, started}, {79'h0, start_cnt != n0});
    rd(`RTP_ADDR_RESP, resp, "resp");
  endtask

  task automatic hf(input logic [55:0] t);
    wr(`RTP_ADDR_WD0, {12'h0, t[55:36]});
    wr(`RTP_ADDR_WD1, {12'h0, t[35:16]});
    run(32'h0103, {t[15:0], 16'h0103}, t[15:0] == 16'h0, 1'b0);
    if (t[15:0] == 16'h0) begin
      check("wr_blocks", blk(t[55:36] | t[35:16]), prot_wr_blocks);
      check("rd_blocks", blk(t[35:16]), prot_rd_blocks);
      check("uhf", 80'h0, {79'h0, prot_uhf});
    end
  endtask

  initial begin
    err_count = 0;
    total_checks = 0;
    resetn = 1'b0;
    clk_en = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    tags_in_range = 8'h01;
    tag_id = 128'h00112233_44556677_8899AABB_CCDDEEFF;
    eng_delay = 8'h01;
    eng_fail = 1'b0;
    eng_err = 16'h0;
    hf_tab = '{{20'hFFFF0, 20'h0, 16'h0}, {20'hFFFFE, 20'hFFFFE, 16'h0},
               {20'h0, 20'h80000, 16'h0}, {20'hFFFF5, 20'h0, 16'h2502},
               {20'hFFFF0, 20'hFFF00, 16'h2502}, {20'h0000F, 20'h0, 16'h2502}};
    uhf_tab = '{{8'h01, 32'h0100, 32'h0, 16'h0}, {8'h01, 32'h0300, 32'h0, 16'h0},
                {8'h01, 32'h0200, 32'h0, 16'h2606}, {8'h01, 32'h0008_0100, 32'h0, 16'h2607},
                {8'h02, 32'h0100, 32'h0, 16'h2603}, {8'h01, 32'h0104, 32'hCCDDEEFF, 16'h0},
                {8'h01, 32'h0104, 32'hCCDDEEF0, 16'h2605}, {8'h01, 32'h01FF, 32'h0, 16'h2605}};
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    rd(`RTP_ADDR_CFG, 32'h0, "cfg");
    rd(`RTP_ADDR_STAT, 32'h0, "stat");
    rd(`RTP_ADDR_RESP, 32'h0, "resp");
    wr(8'h40, 32'hFFFF_FFFF);
    rd(8'h40, 32'h0, "unmapped");
    wr(`RTP_ADDR_CFG, 32'h4);
    wr(`RTP_ADDR_REQ, 32'h0008_0200);
    for (int k = 0; k < 6; k++) begin
      hf(hf_tab[k]);
    end
    wr(`RTP_ADDR_CFG, 32'h0);
    hf({20'h000FF, 20'h0000F, 16'h0});
    wr(`RTP_ADDR_CFG, 32'h5);
    hf({20'hFFFF0, 20'h0, 16'h2602});
    wr(`RTP_ADDR_CFG, 32'h4);
    run(32'h005A_2103, 32'h0000_2103, 1'b1, 1'b0);
    rd(`RTP_ADDR_STAT, 32'h005A_0002, "stat");
    run(32'h0000_0102, 32'h0000_0102, 1'b0, 1'b0);
    wr(`RTP_ADDR_CFG, 32'h2);
    for (int k = 0; k < 8; k++) begin
      tags_in_range <= uhf_tab[k][87:80];
      wr(`RTP_ADDR_REQ, uhf_tab[k][79:48]);
      wr(`RTP_ADDR_WD0, uhf_tab[k][47:16]);
      run(32'h0103, {uhf_tab[k][15:0], 16'h0103}, uhf_tab[k][15:0] == 16'h0, 1'b0);
      if (uhf_tab[k][15:0] == 16'h0) begin
        check("area", {72'h0, uhf_tab[k][63:56]}, {72'h0, prot_area});
        check("uhf", 80'h1, {79'h0, prot_uhf});
      end
    end
    tag_id[7:0] <= 8'h01;
    run(32'h0103, 32'h0000_0103, 1'b1, 1'b0);
    rd(`RTP_ADDR_STAT, 32'h0000_000E, "stat");
    wr(`RTP_ADDR_REQ, 32'h0300);
    eng_delay <= 8'd20;
    eng_fail <= 1'b1;
    eng_err <= 16'h1234;
    run(32'h0103, 32'h1234_0103, 1'b1, 1'b1);
    @(posedge clk);
    clk_en <= 1'b0;
    wr(`RTP_ADDR_CFG, 32'h4);
    clk_en <= 1'b1;
    rd(`RTP_ADDR_CFG, 32'h2, "cfg");
    summarize();
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    summarize();
  end
endmodule

`default_nettype wire
